/* File: verilog/ivai_pkg.sv */
// Constants for the interlaced vertical area and interrupt block
`default_nettype none
package ivai_pkg;
   localparam int CW = 12;
   localparam int AW = 5;
   // Register offsets
   localparam logic [AW-1:0] OFS_CTRL = 5'h00;
   localparam logic [AW-1:0] OFS_START = 5'h04;
   localparam logic [AW-1:0] OFS_END = 5'h08;
   localparam logic [AW-1:0] OFS_INTL = 5'h0c;
   localparam logic [AW-1:0] OFS_FLEN = 5'h10;
   localparam logic [AW-1:0] OFS_LLEN = 5'h14;
   localparam logic [AW-1:0] OFS_STAT = 5'h18;
   // Control and status field positions
   localparam int CTRL_PFI_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int STAT_AREA_BIT = 12;
   localparam int STAT_ODD_BIT = 13;
   // Reset values
   localparam logic [CW-1:0] RST_START = 12'h000;
   localparam logic [CW-1:0] RST_END = 12'h000;
   localparam logic [CW-1:0] RST_INTL = 12'h000;
   localparam logic [CW-1:0] RST_FLEN = 12'h20c;
   localparam logic [CW-1:0] RST_LLEN = 12'h063;
   localparam logic [1:0] RST_CTRL = 2'h0;
endpackage : ivai_pkg
`default_nettype wire

/* File: verilog/ivai_top.sv */
// Interlaced vertical area and frame-timer interrupt compare logic
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ivai_top (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   // Register port
   input wire logic [ivai_pkg::AW-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Video timing
   input wire logic HAREA_I,
   output logic COMPOSITE_AREA_OUT_O,
   output logic FT_INT_O,
   output logic VSYNC_START_O,
   output logic [ivai_pkg::CW-1:0] VERTICAL_HALFLINE_COUNTER_O
);
   localparam int CW = ivai_pkg::CW;

   // Equal, or one above when both fields count
   function automatic logic hl_match(input logic [CW-1:0] v, input logic [CW-1:0] val,
                                     input logic both);
      hl_match = (v == val) || (both && (v == CW'(val + 1'b1)));
   endfunction

   logic [1:0] ctrl_q, ctrl_d;
   logic [CW-1:0] start_q, start_d, end_q, end_d, intl_q, intl_d;
   logic [CW-1:0] flen_q, flen_d, llen_q, llen_d;
   logic [CW-1:0] hcnt_q, hcnt_d, vcnt_q, vcnt_d;
   logic vertical_area_term_q, vertical_area_term_d, odd_q, odd_d;
   logic composite_area_q, composite_area_d, int_q, int_d, vs_q, vs_d;
   logic [31:0] rdata_q, rdata_d;
   logic run, pfi, line_end, mid, step;

   assign run = ctrl_q[ivai_pkg::CTRL_RUN_BIT];
   assign pfi = ctrl_q[ivai_pkg::CTRL_PFI_BIT];
   assign line_end = run && (hcnt_q == llen_q);
   assign mid = run && !line_end && (hcnt_q == (llen_q >> 1));
   assign step = line_end || mid;

   always_comb begin
      ctrl_d = ctrl_q;
      start_d = start_q;
      end_d = end_q;
      intl_d = intl_q;
      flen_d = flen_q;
      llen_d = llen_q;
      rdata_d = 32'h0000_0000;
      if (WR_I) begin
         case (ADDR_I)
            ivai_pkg::OFS_CTRL: ctrl_d = WDATA_I[1:0];
            ivai_pkg::OFS_START: start_d = WDATA_I[CW-1:0];
            ivai_pkg::OFS_END: end_d = WDATA_I[CW-1:0];
            ivai_pkg::OFS_INTL: intl_d = WDATA_I[CW-1:0];
            ivai_pkg::OFS_FLEN: flen_d = WDATA_I[CW-1:0];
            ivai_pkg::OFS_LLEN: llen_d = WDATA_I[CW-1:0];
            default: ;
         endcase
      end
      if (RD_I) begin
         case (ADDR_I)
            ivai_pkg::OFS_CTRL: rdata_d = {30'h0, ctrl_q};
            ivai_pkg::OFS_START: rdata_d = {20'h0, start_q};
            ivai_pkg::OFS_END: rdata_d = {20'h0, end_q};
            ivai_pkg::OFS_INTL: rdata_d = {20'h0, intl_q};
            ivai_pkg::OFS_FLEN: rdata_d = {20'h0, flen_q};
            ivai_pkg::OFS_LLEN: rdata_d = {20'h0, llen_q};
            ivai_pkg::OFS_STAT: rdata_d = {18'h0, odd_q, vertical_area_term_q, vcnt_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      hcnt_d = hcnt_q;
      vcnt_d = vcnt_q;
      odd_d = odd_q;
      vertical_area_term_d = vertical_area_term_q;
      int_d = 1'b0;
      vs_d = 1'b0;
      if (!run) begin
         hcnt_d = '0;
         vcnt_d = '0;
         odd_d = 1'b0;
         vertical_area_term_d = 1'b0;
      end else begin
         hcnt_d = line_end ? '0 : CW'(hcnt_q + 1'b1);
         if (step) begin
            if (vcnt_q == flen_q) begin
               vcnt_d = '0;
               vs_d = 1'b1;
               odd_d = !odd_q;
            end else begin
               vcnt_d = CW'(vcnt_q + 1'b1);
            end
         end
         if (line_end) begin
            // start, value or next in other field
            if (hl_match(vcnt_q, start_q, 1'b1)) begin
               vertical_area_term_d = 1'b1;
            end
            if (hl_match(vcnt_q, end_q, 1'b1)) begin
               vertical_area_term_d = 1'b0;
            end
            int_d = hl_match(vcnt_q, intl_q, pfi);
         end
      end
      composite_area_d = HAREA_I && vertical_area_term_q;
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctrl_q <= ivai_pkg::RST_CTRL;
         start_q <= ivai_pkg::RST_START;
         end_q <= ivai_pkg::RST_END;
         intl_q <= ivai_pkg::RST_INTL;
         flen_q <= ivai_pkg::RST_FLEN;
         llen_q <= ivai_pkg::RST_LLEN;
         hcnt_q <= '0;
         vcnt_q <= '0;
         odd_q <= 1'b0;
         vertical_area_term_q <= 1'b0;
         composite_area_q <= 1'b0;
         int_q <= 1'b0;
         vs_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         start_q <= start_d;
         end_q <= end_d;
         intl_q <= intl_d;
         flen_q <= flen_d;
         llen_q <= llen_d;
         hcnt_q <= hcnt_d;
         vcnt_q <= vcnt_d;
         odd_q <= odd_d;
         vertical_area_term_q <= vertical_area_term_d;
         composite_area_q <= composite_area_d;
         int_q <= int_d;
         vs_q <= vs_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;
   assign COMPOSITE_AREA_OUT_O = composite_area_q;
   assign FT_INT_O = int_q;
   assign VSYNC_START_O = vs_q;
   assign VERTICAL_HALFLINE_COUNTER_O = vcnt_q;

   // Parity helper for line-end checks
   logic seen_q, seen_d, lpar_q, lpar_d;
   always_comb begin
      seen_d = seen_q;
      lpar_d = lpar_q;
      if (!run || (step && vcnt_q == flen_q)) begin
         seen_d = 1'b0;
      end else if (line_end && !seen_q) begin
         seen_d = 1'b1;
         lpar_d = vcnt_q[0];
      end
   end
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         seen_q <= 1'b0;
         lpar_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
         lpar_q <= lpar_d;
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);

   sequence s_start_hit;
      line_end && hl_match(vcnt_q, start_q, 1'b1) && !hl_match(vcnt_q, end_q, 1'b1);
   endsequence
   sequence s_area_on;
      vertical_area_term_q ##1 (vertical_area_term_q || !run || $past(line_end));
   endsequence

   a_mid_step: assert property (mid && vcnt_q != flen_q |=> vcnt_q == CW'($past(vcnt_q) + 1'b1))
      else $error("counter did not step at midpoint");
   a_area_line_end: assert property ($changed(vertical_area_term_q) |->
                                     $past(line_end) || !$past(run))
      else $error("area changed away from line end");
   a_area_start: assert property (s_start_hit |=> s_area_on)
      else $error("area did not start after start match");
   a_par_ntsc: assert property (line_end && seen_q && !lpar_q |-> !vcnt_q[0])
      else $error("line-end parity changed within field");
   a_par_pal: assert property (line_end && seen_q && lpar_q |-> vcnt_q[0])
      else $error("line-end parity changed within field");
   a_int_frame: assert property (line_end && !pfi && vcnt_q != intl_q |=> !FT_INT_O)
      else $error("interrupt without exact match");
   a_int_field: assert property (line_end && pfi && vcnt_q == CW'(intl_q + 1'b1) |=> FT_INT_O)
      else $error("second field interrupt missing");
   a_int_pfi: assert property (line_end && vcnt_q == intl_q |=> FT_INT_O)
      else $error("interrupt missing on match");
   a_area_follow: assert property (vertical_area_term_q && HAREA_I |=> COMPOSITE_AREA_OUT_O)
      else $error("composite area not following");
   a_area_gate: assert property (!(vertical_area_term_q && HAREA_I) |=> !COMPOSITE_AREA_OUT_O)
      else $error("composite area active outside vertical term");
   a_wrap_zero: assert property (step && vcnt_q == flen_q |=> vcnt_q == '0 && VSYNC_START_O)
      else $error("counter did not clear at field length");
   a_int_pulse: assert property (FT_INT_O |-> $past(line_end) ##1 !FT_INT_O)
      else $error("interrupt not a single pulse");
endmodule // ivai_top
`default_nettype wire

/* File: tb/ivai_top_tb_top.sv */
// Self-checking bench for the interlaced vertical area block
`timescale 1ns/10ps
`default_nettype none
module ivai_top_tb_top;
   logic clk = 1'b0;
   logic nrst_n = 1'b0;
   logic [ivai_pkg::AW-1:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic harea = 1'b0;
   logic [31:0] rdata;
   logic comp_area;
   logic ft_int;
   logic vs;
   logic [ivai_pkg::CW-1:0] vcnt;
   logic [ivai_pkg::CW-1:0] vmax;
   int num_errors = 0;
   int samples_checked = 0;
   int n_int;
   int n_area;
   int n_vs;
   int n_step;

   always #10 clk = ~clk;

   ivai_top ivai_top_inst (
      .CLK_SYS_I(clk), .NRST_I(nrst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HAREA_I(harea),
      .COMPOSITE_AREA_OUT_O(comp_area), .FT_INT_O(ft_int), .VSYNC_START_O(vs),
      .VERTICAL_HALFLINE_COUNTER_O(vcnt)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [ivai_pkg::AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [ivai_pkg::AW-1:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask

   // Counts output activity over a fixed number of cycles
   task automatic watch(input int n);
      logic [ivai_pkg::CW-1:0] prev;
      prev = vcnt;
      vmax = '0;
      n_int = 0;
      n_area = 0;
      n_vs = 0;
      n_step = 0;
      repeat (n) begin
         @(negedge clk);
         n_int += (ft_int === 1'b1);
         n_area += (comp_area === 1'b1);
         n_vs += (vs === 1'b1);
         n_step += (vcnt !== prev);
         if (vcnt > vmax) begin
            vmax = vcnt;
         end
         prev = vcnt;
      end
   endtask

   task automatic print_verdict;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Line of 4 cycles, field of 11 half-lines, frame of 44 cycles
   initial begin
      repeat (12) @(posedge clk);
      nrst_n <= 1'b1;
      rd_reg(ivai_pkg::OFS_CTRL, 32'h0);
      rd_reg(ivai_pkg::OFS_START, 32'h0);
      rd_reg(ivai_pkg::OFS_INTL, 32'h0);
      rd_reg(ivai_pkg::OFS_FLEN, {20'h0, ivai_pkg::RST_FLEN});
      rd_reg(ivai_pkg::OFS_LLEN, {20'h0, ivai_pkg::RST_LLEN});
      wr_reg(5'h1c, 32'hffff_ffff);
      rd_reg(5'h1c, 32'h0);
      wr_reg(ivai_pkg::OFS_LLEN, 32'h3);
      wr_reg(ivai_pkg::OFS_FLEN, 32'ha);
      wr_reg(ivai_pkg::OFS_START, 32'h3);
      wr_reg(ivai_pkg::OFS_END, 32'h7);
      wr_reg(ivai_pkg::OFS_INTL, 32'h5);
      rd_reg(ivai_pkg::OFS_END, 32'h7);
      @(posedge clk);
      harea <= 1'b1;
      wr_reg(ivai_pkg::OFS_CTRL, 32'h2);
      watch(8);
      watch(176);
      chk(n_int, 32'h4);
      chk(n_area, 32'h40);
      chk(n_vs, 32'h8);
      chk(n_step, 32'h58);
      chk({20'h0, vmax}, 32'ha);
      wr_reg(ivai_pkg::OFS_CTRL, 32'h3);
      watch(8);
      watch(176);
      chk(n_int, 32'h8);
      chk(n_area, 32'h40);
      @(posedge clk);
      harea <= 1'b0;
      watch(2);
      watch(176);
      chk(n_area, 32'h0);
      wr_reg(ivai_pkg::OFS_CTRL, 32'h0);
      watch(4);
      watch(176);
      chk(n_int + n_vs + n_step, 32'h0);
      rd_reg(ivai_pkg::OFS_STAT, 32'h0);
      print_verdict;
   end
endmodule // ivai_top_tb_top
`default_nettype wire
